// ===== src/mpp_pkg.sv
`default_nettype none
package mpp_pkg;
    // pin group widths
    localparam int PORT_A_W  = 4;
    localparam int PORT_B_W  = 2;
    localparam int PORT_C_W  = 6;
    localparam int OD_W      = 4;
    localparam int IN_ONLY_W = 4;
    localparam int IRQ_N     = 3;
    localparam int IRQ_C_LSB = 3;
    localparam int SYNC_W    = PORT_A_W + PORT_B_W + PORT_C_W + OD_W + IN_ONLY_W;

    // register byte addresses
    localparam logic [7:0] A_OUT     = 8'h00;
    localparam logic [7:0] A_DIR     = 8'h04;
    localparam logic [7:0] A_PULLUP  = 8'h08;
    localparam logic [7:0] A_IN      = 8'h0c;
    localparam logic [7:0] B_OUT     = 8'h10;
    localparam logic [7:0] B_DIR     = 8'h14;
    localparam logic [7:0] B_PULLUP  = 8'h18;
    localparam logic [7:0] B_IN      = 8'h1c;
    localparam logic [7:0] C_OUT     = 8'h20;
    localparam logic [7:0] C_DIR     = 8'h24;
    localparam logic [7:0] C_PULLUP  = 8'h28;
    localparam logic [7:0] C_IN      = 8'h2c;
    localparam logic [7:0] OD_OUT    = 8'h30;
    localparam logic [7:0] OD_DIR    = 8'h34;
    localparam logic [7:0] OD_IN     = 8'h3c;
    localparam logic [7:0] INO_IN    = 8'h4c;
    localparam logic [7:0] IRQ_EDGE  = 8'h50;
    localparam logic [7:0] IRQ_STAT  = 8'h54;

    // edge select field: two bits per interrupt input
    localparam int EDGE_RISE_BIT = 0;
    localparam int EDGE_FALL_BIT = 1;

    // reset values: every pin an input, latches low, pull-ups off
    localparam logic [7:0] DIR_RST    = 8'h00;
    localparam logic [7:0] OUT_RST    = 8'h00;
    localparam logic [7:0] PULLUP_RST = 8'h00;
    localparam logic [5:0] EDGE_RST   = 6'h00;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ===== src/mpp_pin_sync.sv
`default_nettype none
module mpp_pin_sync #(
    parameter int W = 8
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    if (W < 1) begin : g_bad_width
        $error("mpp_pin_sync: width must be positive");
    end

    // meta_ff feeds sync_ff only
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;
endmodule // mpp_pin_sync
`default_nettype wire

// ===== src/mpp_edge_irq.sv
`default_nettype none
module mpp_edge_irq #(
    parameter int N = 3
) (
    input  wire logic           clk_i,
    input  wire logic           rst_i,
    input  wire logic [N-1:0]   level_i,
    input  wire logic [2*N-1:0] edge_sel_i,
    output logic      [N-1:0]   pulse_o
);
    logic [N-1:0] prev_ff;

    if (N < 1 || N > 8) begin : g_bad_count
        $error("mpp_edge_irq: N out of range");
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            prev_ff <= '0;
        end else begin
            prev_ff <= level_i;
        end
    end

    // rising only, falling only or both, per input
    for (genvar i = 0; i < N; i++) begin : g_edge
        assign pulse_o[i] = (level_i[i] & ~prev_ff[i] & edge_sel_i[2*i+mpp_pkg::EDGE_RISE_BIT])
                          | (~level_i[i] & prev_ff[i] & edge_sel_i[2*i+mpp_pkg::EDGE_FALL_BIT]);
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_edge_none: assert property (edge_sel_i[1:0] == 2'h0 |-> !pulse_o[0])
        else $error("pulse with no edge selected");
endmodule // mpp_edge_irq
`default_nettype wire

// ===== src/mpp_top.sv
`default_nettype none
module mpp_top #(
    parameter int A_W   = mpp_pkg::PORT_A_W,
    parameter int B_W   = mpp_pkg::PORT_B_W,
    parameter int C_W   = mpp_pkg::PORT_C_W,
    parameter int OD_W  = mpp_pkg::OD_W,
    parameter int INO_W = mpp_pkg::IN_ONLY_W
) (
    input  wire logic              CLOCK_I,
    input  wire logic              RST_I,
    input  wire logic [7:0]        AWADDR_I,
    input  wire logic              AWVALID_I,
    output logic                   AWREADY_O,
    input  wire logic [31:0]       WDATA_I,
    input  wire logic [3:0]        WSTRB_I,
    input  wire logic              WVALID_I,
    output logic                   WREADY_O,
    output logic [1:0]             BRESP_O,
    output logic                   BVALID_O,
    input  wire logic              BREADY_I,
    input  wire logic [7:0]        ARADDR_I,
    input  wire logic              ARVALID_I,
    output logic                   ARREADY_O,
    output logic [31:0]            RDATA_O,
    output logic [1:0]             RRESP_O,
    output logic                   RVALID_O,
    input  wire logic              RREADY_I,
    input  wire logic [A_W-1:0]    PORT_A_PINS_I,
    output logic [A_W-1:0]         PORT_A_PINS_O,
    output logic [A_W-1:0]         PORT_A_PINS_OE_O,
    output logic [A_W-1:0]         PORT_A_PULLUP_O,
    input  wire logic [B_W-1:0]    PORT_B_PINS_I,
    output logic [B_W-1:0]         PORT_B_PINS_O,
    output logic [B_W-1:0]         PORT_B_PINS_OE_O,
    output logic [B_W-1:0]         PORT_B_PULLUP_O,
    input  wire logic [C_W-1:0]    PORT_C_PINS_I,
    output logic [C_W-1:0]         PORT_C_PINS_O,
    output logic [C_W-1:0]         PORT_C_PINS_OE_O,
    output logic [C_W-1:0]         PORT_C_PULLUP_O,
    input  wire logic [OD_W-1:0]   OPEN_DRAIN_PORT_PINS_I,
    output logic [OD_W-1:0]        OPEN_DRAIN_PORT_PINS_O,
    output logic [OD_W-1:0]        OPEN_DRAIN_PORT_PINS_OE_O,
    input  wire logic [INO_W-1:0]  INPUT_ONLY_PORT_PINS_I,
    output logic [2:0]             EXT_IRQ_REQ_O
);
    localparam int SW = A_W + B_W + C_W + OD_W + INO_W;

    if (A_W < 1 || A_W > 8 || B_W < 1 || B_W > 8 || OD_W < 1 || OD_W > 8 || INO_W < 1 || INO_W > 8) begin : g_bad_width
        $error("mpp_top: port widths must be 1 to 8");
    end
    if (C_W < mpp_pkg::IRQ_C_LSB + mpp_pkg::IRQ_N || C_W > 8) begin : g_bad_c_width
        $error("mpp_top: port C must hold the interrupt pins");
    end

    // configuration latches
    logic [A_W-1:0]   a_out_ff, a_dir_ff, a_pu_ff;
    logic [B_W-1:0]   b_out_ff, b_dir_ff, b_pu_ff;
    logic [C_W-1:0]   c_out_ff, c_dir_ff, c_pu_ff;
    logic [OD_W-1:0]  od_out_ff, od_dir_ff;
    logic [5:0]       irq_sel_ff;
    logic [2:0]       irq_flag_ff;
    logic [2:0]       irq_pulse;

    // bus state
    logic             awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic [7:0]       awaddr_ff;
    logic [31:0]      wdata_ff;
    logic             wstrb0_ff;
    logic [1:0]       bresp_ff, rresp_ff;
    logic [31:0]      rdata_ff;

    // pin output flops
    logic [A_W-1:0]   a_pin_ff, a_oe_ff, a_pull_ff;
    logic [B_W-1:0]   b_pin_ff, b_oe_ff, b_pull_ff;
    logic [C_W-1:0]   c_pin_ff, c_oe_ff, c_pull_ff;
    logic [OD_W-1:0]  od_pin_ff, od_oe_ff;

    // synchronised pin levels
    logic [SW-1:0]    sync_all;
    logic [A_W-1:0]   a_sync;
    logic [B_W-1:0]   b_sync;
    logic [C_W-1:0]   c_sync;
    logic [OD_W-1:0]  od_sync;
    logic [INO_W-1:0] ino_sync;

    mpp_pin_sync #(.W(SW)) u_sync (
        .clk_i   (CLOCK_I),
        .rst_i   (RST_I),
        .async_i ({INPUT_ONLY_PORT_PINS_I, OPEN_DRAIN_PORT_PINS_I, PORT_C_PINS_I, PORT_B_PINS_I, PORT_A_PINS_I}),
        .sync_o  (sync_all)
    );

    assign {ino_sync, od_sync, c_sync, b_sync, a_sync} = sync_all;

    mpp_edge_irq #(.N(mpp_pkg::IRQ_N)) u_edge (
        .clk_i      (CLOCK_I),
        .rst_i      (RST_I),
        .level_i    (c_sync[mpp_pkg::IRQ_C_LSB +: mpp_pkg::IRQ_N]),
        .edge_sel_i (irq_sel_ff),
        .pulse_o    (irq_pulse)
    );

    // readback: A, B and C outputs show their latch, inputs the pin
    logic [A_W-1:0]  a_rd;
    logic [B_W-1:0]  b_rd;
    logic [C_W-1:0]  c_rd;
    logic [OD_W-1:0] od_rd;
    assign a_rd  = (a_dir_ff & a_out_ff) | (~a_dir_ff & a_sync);
    assign b_rd  = (b_dir_ff & b_out_ff) | (~b_dir_ff & b_sync);
    assign c_rd  = (c_dir_ff & c_out_ff) | (~c_dir_ff & c_sync);
    assign od_rd = od_sync;  // open drain reads the wire so a held-low line shows

    function automatic logic is_mapped(input logic [7:0] a);
        case (a)
            mpp_pkg::A_OUT, mpp_pkg::A_DIR, mpp_pkg::A_PULLUP, mpp_pkg::A_IN,
            mpp_pkg::B_OUT, mpp_pkg::B_DIR, mpp_pkg::B_PULLUP, mpp_pkg::B_IN,
            mpp_pkg::C_OUT, mpp_pkg::C_DIR, mpp_pkg::C_PULLUP, mpp_pkg::C_IN,
            mpp_pkg::OD_OUT, mpp_pkg::OD_DIR, mpp_pkg::OD_IN, mpp_pkg::INO_IN,
            mpp_pkg::IRQ_EDGE, mpp_pkg::IRQ_STAT: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction

    function automatic logic [31:0] rd_mux(input logic [7:0] a);
        case (a)
            mpp_pkg::A_OUT:    rd_mux = 32'(a_out_ff);
            mpp_pkg::A_DIR:    rd_mux = 32'(a_dir_ff);
            mpp_pkg::A_PULLUP: rd_mux = 32'(a_pu_ff);
            mpp_pkg::A_IN:     rd_mux = 32'(a_rd);
            mpp_pkg::B_OUT:    rd_mux = 32'(b_out_ff);
            mpp_pkg::B_DIR:    rd_mux = 32'(b_dir_ff);
            mpp_pkg::B_PULLUP: rd_mux = 32'(b_pu_ff);
            mpp_pkg::B_IN:     rd_mux = 32'(b_rd);
            mpp_pkg::C_OUT:    rd_mux = 32'(c_out_ff);
            mpp_pkg::C_DIR:    rd_mux = 32'(c_dir_ff);
            mpp_pkg::C_PULLUP: rd_mux = 32'(c_pu_ff);
            mpp_pkg::C_IN:     rd_mux = 32'(c_rd);
            mpp_pkg::OD_OUT:   rd_mux = 32'(od_out_ff);
            mpp_pkg::OD_DIR:   rd_mux = 32'(od_dir_ff);
            mpp_pkg::OD_IN:    rd_mux = 32'(od_rd);
            mpp_pkg::INO_IN:   rd_mux = 32'(ino_sync);
            mpp_pkg::IRQ_EDGE: rd_mux = 32'(irq_sel_ff);
            mpp_pkg::IRQ_STAT: rd_mux = 32'(irq_flag_ff);
            default:           rd_mux = 32'h0;
        endcase
    endfunction

    // write channel: address and data taken in either order, answer once both are held
    logic do_write;
    logic wr_en;
    assign do_write = !awready_ff && !wready_ff && !bvalid_ff;
    assign wr_en    = do_write && wstrb0_ff && is_mapped(awaddr_ff);

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            awready_ff <= 1'b1;
            wready_ff  <= 1'b1;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= mpp_pkg::RESP_OKAY;
            awaddr_ff  <= 8'h00;
            wdata_ff   <= 32'h0;
            wstrb0_ff  <= 1'b0;
        end else begin
            if (AWVALID_I && awready_ff) begin
                awready_ff <= 1'b0;
                awaddr_ff  <= {AWADDR_I[7:2], 2'h0};
            end
            if (WVALID_I && wready_ff) begin
                wready_ff <= 1'b0;
                wdata_ff  <= WDATA_I;
                wstrb0_ff <= WSTRB_I[0];
            end
            if (do_write) begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= is_mapped(awaddr_ff) ? mpp_pkg::RESP_OKAY : mpp_pkg::RESP_SLVERR;
            end
            if (bvalid_ff && BREADY_I) begin
                bvalid_ff  <= 1'b0;
                awready_ff <= 1'b1;
                wready_ff  <= 1'b1;
            end
        end
    end

    // read channel: one cycle from address to data
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0;
            rresp_ff   <= mpp_pkg::RESP_OKAY;
        end else if (ARVALID_I && arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b1;
            rdata_ff   <= rd_mux({ARADDR_I[7:2], 2'h0});
            rresp_ff   <= is_mapped({ARADDR_I[7:2], 2'h0}) ? mpp_pkg::RESP_OKAY : mpp_pkg::RESP_SLVERR;
        end else if (rvalid_ff && RREADY_I) begin
            rvalid_ff  <= 1'b0;
            arready_ff <= 1'b1;
        end
    end

    // port latches; only byte lane 0 carries data
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            a_dir_ff  <= A_W'(mpp_pkg::DIR_RST);
            b_dir_ff  <= B_W'(mpp_pkg::DIR_RST);
            c_dir_ff  <= C_W'(mpp_pkg::DIR_RST);
            od_dir_ff <= OD_W'(mpp_pkg::DIR_RST);
            a_out_ff  <= A_W'(mpp_pkg::OUT_RST);
            b_out_ff  <= B_W'(mpp_pkg::OUT_RST);
            c_out_ff  <= C_W'(mpp_pkg::OUT_RST);
            od_out_ff <= OD_W'(mpp_pkg::OUT_RST);
            a_pu_ff   <= A_W'(mpp_pkg::PULLUP_RST);
            b_pu_ff   <= B_W'(mpp_pkg::PULLUP_RST);
            c_pu_ff   <= C_W'(mpp_pkg::PULLUP_RST);
        end else if (wr_en) begin
            case (awaddr_ff)
                mpp_pkg::A_OUT:    a_out_ff  <= wdata_ff[A_W-1:0];
                mpp_pkg::A_DIR:    a_dir_ff  <= wdata_ff[A_W-1:0];
                mpp_pkg::A_PULLUP: a_pu_ff   <= wdata_ff[A_W-1:0];
                mpp_pkg::B_OUT:    b_out_ff  <= wdata_ff[B_W-1:0];
                mpp_pkg::B_DIR:    b_dir_ff  <= wdata_ff[B_W-1:0];
                mpp_pkg::B_PULLUP: b_pu_ff   <= wdata_ff[B_W-1:0];
                mpp_pkg::C_OUT:    c_out_ff  <= wdata_ff[C_W-1:0];
                mpp_pkg::C_DIR:    c_dir_ff  <= wdata_ff[C_W-1:0];
                mpp_pkg::C_PULLUP: c_pu_ff   <= wdata_ff[C_W-1:0];
                mpp_pkg::OD_OUT:   od_out_ff <= wdata_ff[OD_W-1:0];
                mpp_pkg::OD_DIR:   od_dir_ff <= wdata_ff[OD_W-1:0];
                default: ;
            endcase
        end
    end

    // interrupt edge select and sticky requests; a new edge beats a clear
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            irq_sel_ff  <= mpp_pkg::EDGE_RST;
            irq_flag_ff <= 3'h0;
        end else begin
            if (wr_en && awaddr_ff == mpp_pkg::IRQ_EDGE) begin
                irq_sel_ff <= wdata_ff[5:0];
            end
            if (wr_en && awaddr_ff == mpp_pkg::IRQ_STAT) begin
                irq_flag_ff <= (irq_flag_ff & ~wdata_ff[2:0]) | irq_pulse;
            end else begin
                irq_flag_ff <= irq_flag_ff | irq_pulse;
            end
        end
    end

    // pin drivers; pull-up only while the pin is an input
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            a_pin_ff  <= '0;
            a_oe_ff   <= '0;
            a_pull_ff <= '0;
            b_pin_ff  <= '0;
            b_oe_ff   <= '0;
            b_pull_ff <= '0;
            c_pin_ff  <= '0;
            c_oe_ff   <= '0;
            c_pull_ff <= '0;
            od_pin_ff <= '0;
            od_oe_ff  <= '0;
        end else begin
            a_pin_ff  <= a_out_ff;
            a_oe_ff   <= a_dir_ff;
            a_pull_ff <= a_pu_ff & ~a_dir_ff;
            b_pin_ff  <= b_out_ff;
            b_oe_ff   <= b_dir_ff;
            b_pull_ff <= b_pu_ff & ~b_dir_ff;
            c_pin_ff  <= c_out_ff;
            c_oe_ff   <= c_dir_ff;
            c_pull_ff <= c_pu_ff & ~c_dir_ff;
            od_pin_ff <= '0;
            od_oe_ff  <= od_dir_ff & ~od_out_ff;
        end
    end

    assign AWREADY_O                 = awready_ff;
    assign WREADY_O                  = wready_ff;
    assign BVALID_O                  = bvalid_ff;
    assign BRESP_O                   = bresp_ff;
    assign ARREADY_O                 = arready_ff;
    assign RVALID_O                  = rvalid_ff;
    assign RDATA_O                   = rdata_ff;
    assign RRESP_O                   = rresp_ff;
    assign PORT_A_PINS_O             = a_pin_ff;
    assign PORT_A_PINS_OE_O          = a_oe_ff;
    assign PORT_A_PULLUP_O           = a_pull_ff;
    assign PORT_B_PINS_O             = b_pin_ff;
    assign PORT_B_PINS_OE_O          = b_oe_ff;
    assign PORT_B_PULLUP_O           = b_pull_ff;
    assign PORT_C_PINS_O             = c_pin_ff;
    assign PORT_C_PINS_OE_O          = c_oe_ff;
    assign PORT_C_PULLUP_O           = c_pull_ff;
    assign OPEN_DRAIN_PORT_PINS_O    = od_pin_ff;
    assign OPEN_DRAIN_PORT_PINS_OE_O = od_oe_ff;
    assign EXT_IRQ_REQ_O             = irq_flag_ff;

    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);

    chk_a_dir_oe: assert property (##1 PORT_A_PINS_OE_O == $past(a_dir_ff))
        else $error("port A enable does not follow direction");
    chk_b_dir_oe: assert property (##1 PORT_B_PINS_OE_O == $past(b_dir_ff))
        else $error("port B enable does not follow direction");
    chk_c_dir_oe: assert property (##1 PORT_C_PINS_OE_O == $past(c_dir_ff))
        else $error("port C enable does not follow direction");
    chk_pullup_input_only: assert property ((PORT_C_PULLUP_O & PORT_C_PINS_OE_O) == '0 &&
                                            (PORT_B_PULLUP_O & PORT_B_PINS_OE_O) == '0 &&
                                            (PORT_A_PULLUP_O & PORT_A_PINS_OE_O) == '0)
        else $error("pull-up active on an output pin");
    chk_od_low_only: assert property ((OPEN_DRAIN_PORT_PINS_O == '0) and
                                      (##1 (OPEN_DRAIN_PORT_PINS_OE_O == $past(od_dir_ff & ~od_out_ff))))
        else $error("open-drain pin driven high or enable wrong");
    chk_ino_read: assert property (ARVALID_I && ARREADY_O && ARADDR_I == mpp_pkg::INO_IN
                                   |=> RVALID_O && RDATA_O == 32'($past(ino_sync)))
        else $error("input-only read returned wrong level");
    chk_irq_rise: assert property ($rose(c_sync[mpp_pkg::IRQ_C_LSB]) && irq_sel_ff[mpp_pkg::EDGE_RISE_BIT]
                                   |=> EXT_IRQ_REQ_O[0])
        else $error("rising edge did not raise request 0");
    chk_irq_hold: assert property (EXT_IRQ_REQ_O[2] && !(wr_en && awaddr_ff == mpp_pkg::IRQ_STAT)
                                   |=> EXT_IRQ_REQ_O[2])
        else $error("request 2 dropped without a clear");
    chk_out_drive: assert property (a_dir_ff[0] ##1 a_dir_ff[0] |-> PORT_A_PINS_O[0] == $past(a_out_ff[0]))
        else $error("output pin does not drive its latch");
    chk_b_stable: assert property (BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O))
        else $error("write response dropped before taken");

    cov_write_dir: cover property (wr_en && awaddr_ff == mpp_pkg::A_DIR);
    cov_irq_fall: cover property ($fell(c_sync[mpp_pkg::IRQ_C_LSB + 1]) ##1 EXT_IRQ_REQ_O[1]);
    cov_bad_read: cover property (RVALID_O && RRESP_O == mpp_pkg::RESP_SLVERR);
endmodule // mpp_top
`default_nettype wire

// ===== verif/mpp_board.sv
`default_nettype none
module mpp_board #(
    parameter int           W  = 20,
    parameter logic [W-1:0] OD = '0
) (
    input  wire logic         clk_i,
    input  wire logic [W-1:0] drv_i,
    input  wire logic [W-1:0] oe_i,
    input  wire logic [W-1:0] pu_i,
    input  wire logic [W-1:0] ext_en_i,
    input  wire logic [W-1:0] ext_val_i,
    output logic      [W-1:0] pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // a released line without pull-up toggles, so a stale level never reads as valid
    logic [W-1:0] last_ff;
    always_ff @(posedge clk_i) last_ff <= pin_o;
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (oe_i[i]) pin_o[i] = OD[i] ? 1'h0 : drv_i[i];
            else if (ext_en_i[i]) pin_o[i] = ext_val_i[i];
            else pin_o[i] = (pu_i[i] | OD[i]) ? 1'h1 : ~last_ff[i];
        end
    end
endmodule // mpp_board
`default_nettype wire

// ===== verif/mpp_top_tb.sv
`default_nettype none
module mpp_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [1:0] OK = mpp_pkg::RESP_OKAY;
    logic            CLOCK_I, RST_I, AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I;
    logic [7:0]      AWADDR_I, ARADDR_I;
    logic [31:0]     WDATA_I;
    logic [3:0]      WSTRB_I;
    wire logic       AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O;
    wire logic [1:0] BRESP_O, RRESP_O;
    wire logic [31:0] RDATA_O;
    wire logic [3:0] PORT_A_PINS_I, PORT_A_PINS_O, PORT_A_PINS_OE_O, PORT_A_PULLUP_O;
    wire logic [1:0] PORT_B_PINS_I, PORT_B_PINS_O, PORT_B_PINS_OE_O, PORT_B_PULLUP_O;
    wire logic [5:0] PORT_C_PINS_I, PORT_C_PINS_O, PORT_C_PINS_OE_O, PORT_C_PULLUP_O;
    wire logic [3:0] OPEN_DRAIN_PORT_PINS_I, OPEN_DRAIN_PORT_PINS_O, OPEN_DRAIN_PORT_PINS_OE_O;
    wire logic [3:0] INPUT_ONLY_PORT_PINS_I;
    wire logic [2:0] EXT_IRQ_REQ_O;
    wire logic [19:0] pins;
    logic [19:0]     ext_en, ext_val;
    logic [33:0]     rq[$];
    logic [1:0]      bq[$];
    int              err_count, checks;
    wire logic [11:0] oe12 = {PORT_C_PINS_OE_O, PORT_B_PINS_OE_O, PORT_A_PINS_OE_O};
    wire logic [11:0] o12  = {PORT_C_PINS_O, PORT_B_PINS_O, PORT_A_PINS_O};
    wire logic [11:0] pu12 = {PORT_C_PULLUP_O, PORT_B_PULLUP_O, PORT_A_PULLUP_O};
    assign {INPUT_ONLY_PORT_PINS_I, OPEN_DRAIN_PORT_PINS_I, PORT_C_PINS_I, PORT_B_PINS_I, PORT_A_PINS_I} = pins;
    mpp_top mpp_top_inst (.*);
    mpp_board #(.W(20), .OD(20'h0f000)) board_inst (.clk_i(CLOCK_I),
        .drv_i({4'h0, OPEN_DRAIN_PORT_PINS_O, o12}), .oe_i({4'h0, OPEN_DRAIN_PORT_PINS_OE_O, oe12}),
        .pu_i({8'h0, pu12}), .ext_en_i(ext_en), .ext_val_i(ext_val), .pin_o(pins));
    task automatic end_of_test();
        if (err_count == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        bq.push_back(r);
        @(posedge CLOCK_I);
        AWADDR_I <= a;
        WDATA_I <= d;
        AWVALID_I <= 1'h1;
        WVALID_I <= 1'h1;
        BREADY_I <= 1'h1;
        // no cycle count assumed: only the watchdog ends a stuck wait
        do begin
            @(posedge CLOCK_I);
            if (AWREADY_O === 1'h1) AWVALID_I <= 1'h0;
            if (WREADY_O === 1'h1) WVALID_I <= 1'h0;
        end while (BVALID_O !== 1'h1);
        BREADY_I <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        rq.push_back(e);
        @(posedge CLOCK_I);
        ARADDR_I <= a;
        ARVALID_I <= 1'h1;
        RREADY_I <= 1'h1;
        do begin
            @(posedge CLOCK_I);
            if (ARREADY_O === 1'h1) ARVALID_I <= 1'h0;
        end while (RVALID_O !== 1'h1);
        RREADY_I <= 1'h0;
    endtask
    always @(posedge CLOCK_I) begin
        if (BVALID_O === 1'h1 && BREADY_I && bq.size() > 0) cmp({32'h0, BRESP_O}, {32'h0, bq.pop_front()});
        if (RVALID_O === 1'h1 && RREADY_I && rq.size() > 0) cmp({RRESP_O, RDATA_O}, rq.pop_front());
    end
    initial begin
        CLOCK_I = 1'h0;
        forever #20 CLOCK_I = ~CLOCK_I;
    end
    initial begin
        repeat (20000) @(posedge CLOCK_I);
        err_count++;
        end_of_test();
    end
    initial begin
        logic [11:0] dir, out, pu, val;
        logic [3:0]  odd, odl;
        int          off[3];
        logic [11:0] msk[3];
        err_count = 0;
        checks = 0;
        off = '{0, 4, 6};
        msk = '{12'h00f, 12'h030, 12'hfc0};
        {RST_I, AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I} = 6'h20;
        {AWADDR_I, ARADDR_I, WDATA_I} = 48'h0;
        WSTRB_I = 4'hf;
        ext_en = 20'hfffff;
        ext_val = 20'h0;
        void'($urandom(32'hcde0));
        repeat (4) @(posedge CLOCK_I);
        RST_I <= 1'h0;
        cmp({18'h0, OPEN_DRAIN_PORT_PINS_OE_O, oe12}, 34'h0);
        for (int g = 0; g < 3; g++) begin
            rd(8'(g * 16 + 4), 34'h0);
            rd(8'(g * 16 + 8), 34'h0);
        end
        rd(mpp_pkg::OD_DIR, 34'h0);
        repeat (3) begin
            {dir, out, pu, val} = 48'({$urandom, $urandom});
            ext_en[11:0] <= ~dir & ~pu;
            ext_val[11:0] <= val;
            for (int g = 0; g < 3; g++) begin
                wr(8'(g * 16), 32'((out & msk[g]) >> off[g]), OK);
                wr(8'(g * 16 + 4), 32'((dir & msk[g]) >> off[g]), OK);
                wr(8'(g * 16 + 8), 32'((pu & msk[g]) >> off[g]), OK);
            end
            repeat (3) @(posedge CLOCK_I);
            cmp({22'h0, oe12}, {22'h0, dir});
            cmp({22'h0, o12 & dir}, {22'h0, out & dir});
            cmp({22'h0, pu12}, {22'h0, pu & ~dir});
            for (int g = 0; g < 3; g++)
                rd(8'(g * 16 + 12), {2'h0, 32'((((out & dir) | (~dir & (pu | val))) & msk[g]) >> off[g])});
        end
        // open-drain lines rely on the board resistor when released
        ext_en[15:12] <= 4'h0;
        repeat (3) begin
            {odd, odl} = 8'($urandom);
            wr(mpp_pkg::OD_OUT, {28'h0, odl}, OK);
            wr(mpp_pkg::OD_DIR, {28'h0, odd}, OK);
            repeat (3) @(posedge CLOCK_I);
            cmp({26'h0, OPEN_DRAIN_PORT_PINS_OE_O, OPEN_DRAIN_PORT_PINS_O}, {26'h0, odd & ~odl, 4'h0});
            rd(mpp_pkg::OD_IN, {30'h0, ~(odd & ~odl)});
        end
        ext_val[19:16] <= 4'($urandom);
        repeat (3) @(posedge CLOCK_I);
        rd(mpp_pkg::INO_IN, {30'h0, ext_val[19:16]});
        wr(8'h44, 32'hf, mpp_pkg::RESP_SLVERR);
        rd(8'h44, {mpp_pkg::RESP_SLVERR, 32'h0});
        wr(mpp_pkg::C_DIR, 32'h0, OK);
        // lane 0 strobe low: answered but must leave the latch alone
        WSTRB_I <= 4'he;
        wr(mpp_pkg::C_DIR, 32'h3f, OK);
        WSTRB_I <= 4'hf;
        rd(mpp_pkg::C_DIR, 34'h0);
        ext_en[11:9] <= 3'h7;
        for (int m = 1; m < 4; m++) begin
            ext_val[11:9] <= 3'h0;
            wr(mpp_pkg::IRQ_EDGE, 32'({3{2'(m)}}), OK);
            repeat (4) @(posedge CLOCK_I);
            wr(mpp_pkg::IRQ_STAT, 32'h7, OK);
            ext_val[11:9] <= 3'h7;
            repeat (5) @(posedge CLOCK_I);
            cmp({31'h0, EXT_IRQ_REQ_O}, {31'h0, m[0] ? 3'h7 : 3'h0});
            rd(mpp_pkg::IRQ_STAT, {31'h0, m[0] ? 3'h7 : 3'h0});
            wr(mpp_pkg::IRQ_STAT, 32'h7, OK);
            ext_val[11:9] <= 3'h0;
            repeat (5) @(posedge CLOCK_I);
            rd(mpp_pkg::IRQ_STAT, {31'h0, m[1] ? 3'h7 : 3'h0});
        end
        end_of_test();
    end
endmodule // mpp_top_tb
`default_nettype wire
